// file: verilog/pcdfc_clock_control.sv
/*
 * Divider chain, output freeze control, feedback selection and phase detector.
 * Assumes clock is the VCO; straps and freeze pins are synchronous to it and
 * the pad logic builds the high-impedance pins from clocksOutEnable.
 */
`timescale 1ns/1ps
module pcdfc_clock_control (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic master_reset_hiz_n,
    input wire logic pllEnable,
    input wire logic vco_range_select,
    input wire logic test_reference_clock_in,
    input wire logic feedback_source_select,
    input wire logic externalFeedback,
    input wire logic [1:0] busDivSelect,
    input wire logic [1:0] localDivSelect,
    input wire logic freezeSerialClock,
    input wire logic freezeSerialData,
    input wire logic commonFreeze,
    input wire logic freezeStrobe,
    output pcdfc_pkg::pcdfc_clocks_t clocksOut,
    output logic clocksOutEnable,
    output logic detectorFeedback,
    output logic phaseUp,
    output logic phaseDown
);
    import pcdfc_pkg::*;

    logic clr;
    logic halfPhase_q;
    logic tcPrev_q;
    logic tcRise;
    logic tick;
    logic [1:0] tickCnt_q;
    logic [2:0] busRatio;
    logic [BUS_CNT_WIDTH-1:0] busPeriod;
    logic [BUS_CNT_WIDTH-1:0] busCnt_q;
    logic busWrap;
    logic [1:0] locCnt_q;
    logic [1:0] locLast;
    logic [LOCAL_POS_WIDTH-1:0] localPos;
    logic [LOCAL_POS_WIDTH-1:0] localHalf;
    logic [NUM_OUTPUTS-1:0] raw;
    logic [INT_FB_WIDTH-1:0] fbCnt_q;
    logic fbSel;
    logic fbPrev_q;
    logic refPrev_q;
    logic fbRise;
    logic refRise;
    logic serClkPrev_q;
    logic strobePrev_q;
    logic serRise;
    logic strobeFall;
    logic [NUM_OUTPUTS-1:0] shift_q;
    logic [NUM_OUTPUTS-1:0] shiftNext;
    logic [NUM_OUTPUTS-1:0] reqEn_q;
    logic [NUM_OUTPUTS-1:0] appliedEn_q;
    logic [NUM_OUTPUTS-1:0] out_q;
    logic oe_q;
    logic detFb_q;
    logic up_q;
    logic down_q;

    // Master reset acts as a synchronous reset of every flop: enables set to all ones, the rest cleared
    assign clr = ~master_reset_hiz_n;

    // Divider advance: VCO path with optional halving, or test clock edges in bypass
    assign tcRise = test_reference_clock_in & ~tcPrev_q;
    assign tick = pllEnable ? (vco_range_select | halfPhase_q) : tcRise;

    // Bus and local bus ratios; all divider chain counters share one tick so phases stay locked
    assign busRatio = {1'b0, busDivSelect} + 3'h1;
    assign busPeriod = BUS_CNT_WIDTH'(int'(busRatio) * PROCESSOR_CLOCK_ENABLE_OUT_TICKS);
    assign busWrap = (busCnt_q == busPeriod - BUS_CNT_WIDTH'(1));
    assign locLast = localDivSelect;
    assign localPos = LOCAL_POS_WIDTH'(int'(locCnt_q) * int'(busPeriod) + int'(busCnt_q));
    assign localHalf = LOCAL_POS_WIDTH'((int'(localDivSelect) + 1) * int'(busPeriod) / 2);

    // Raw waveforms before freeze gating
    // Every wave is decoded from the shared counters, never from another output
    assign raw[IDX_DOUBLE] = tickCnt_q[0];
    assign raw[IDX_PROCESSOR_CLOCK_ENABLE_OUT] = tickCnt_q[1];
    assign raw[IDX_BUS] = (busCnt_q < (busPeriod >> 1));
    // Enable high during the last processor enable period of each bus cycle
    assign raw[IDX_BUS_CLOCK_ENABLE_OUT] = (busCnt_q >= busPeriod - BUS_CNT_WIDTH'(PROCESSOR_CLOCK_ENABLE_OUT_TICKS));
    assign raw[IDX_LOCAL] = (localDivSelect == LOCAL_SEL_PROCESSOR_CLOCK_ENABLE_OUT) ? tickCnt_q[1] : (localPos < localHalf);

    // Feedback choice and edge detection for the phase detector
    assign fbSel = feedback_source_select ? fbCnt_q[INT_FB_WIDTH-1] : externalFeedback;
    assign fbRise = fbSel & ~fbPrev_q;
    assign refRise = test_reference_clock_in & ~refPrev_q;

    // Freeze port edges; the next serial word shifts in at bit 0
    assign serRise = freezeSerialClock & ~serClkPrev_q;
    assign strobeFall = ~freezeStrobe & strobePrev_q;
    assign shiftNext = {shift_q[NUM_OUTPUTS-2:0], freezeSerialData};

    // Edge history of the sampled inputs
    // Histories clear with master reset, so an input already high then shows an edge on release
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tcPrev_q <= 1'b0;
            serClkPrev_q <= 1'b0;
            strobePrev_q <= 1'b0;
            refPrev_q <= 1'b0;
            fbPrev_q <= 1'b0;
        end else begin
            tcPrev_q <= test_reference_clock_in & ~clr;
            serClkPrev_q <= freezeSerialClock & ~clr;
            strobePrev_q <= freezeStrobe & ~clr;
            refPrev_q <= test_reference_clock_in & ~clr;
            fbPrev_q <= fbSel & ~clr;
        end
    end

    // Halving stage after the VCO
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            halfPhase_q <= 1'b0;
        end else begin
            halfPhase_q <= clr ? 1'b0 : ~halfPhase_q;
        end
    end

    // Divider chain keeps running whatever the freeze state
    // Straps are read live; a change between resets can step the local counter off its phase
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tickCnt_q <= 2'h0;
            busCnt_q <= '0;
            locCnt_q <= 2'h0;
        end else if (clr) begin
            tickCnt_q <= 2'h0;
            busCnt_q <= '0;
            locCnt_q <= 2'h0;
        end else if (tick) begin
            tickCnt_q <= tickCnt_q + 2'h1;
            busCnt_q <= busWrap ? '0 : busCnt_q + BUS_CNT_WIDTH'(1);
            if (busWrap) begin
                locCnt_q <= (locCnt_q >= locLast) ? 2'h0 : locCnt_q + 2'h1;
            end
        end
    end

    // Internal feedback divider runs on every VCO cycle
    // Not gated by the halving stage or bypass, so the fixed ratio is always to the VCO
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fbCnt_q <= '0;
        end else begin
            fbCnt_q <= clr ? '0 : fbCnt_q + INT_FB_WIDTH'(1);
        end
    end

    // Three-state phase frequency detector; both set means clear both
    // A model on sampled edges: it tells the direction of the error and, by pulse width, its size in whole clocks
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            up_q <= 1'b0;
            down_q <= 1'b0;
            detFb_q <= 1'b0;
        end else if (clr) begin
            up_q <= 1'b0;
            down_q <= 1'b0;
            detFb_q <= 1'b0;
        end else begin
            detFb_q <= fbSel;
            up_q <= (up_q | refRise) & ~(down_q | fbRise);
            down_q <= (down_q | fbRise) & ~(up_q | refRise);
        end
    end

    // Freeze requests; the common strobe wins over a serial edge in the same cycle
    // Each serial edge loads the partial word too, so outputs follow the word as it builds
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            shift_q <= ENABLES_RESET;
            reqEn_q <= ENABLES_RESET;
        end else if (clr) begin
            shift_q <= ENABLES_RESET;
            reqEn_q <= ENABLES_RESET;
        end else if (strobeFall) begin
            reqEn_q <= {NUM_OUTPUTS{~commonFreeze}};
        end else if (serRise) begin
            shift_q <= shiftNext;
            reqEn_q <= shiftNext;
        end
    end

    // Per output: take a new enable only while the raw wave is low
    // Holding the old enable through a high phase is what keeps runt pulses off the pins
    generate
        for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_gate
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    appliedEn_q[i] <= ENABLES_RESET[i];
                    out_q[i] <= 1'b0;
                end else if (clr) begin
                    appliedEn_q[i] <= ENABLES_RESET[i];
                    out_q[i] <= 1'b0;
                end else begin
                    if (!raw[i]) begin
                        appliedEn_q[i] <= reqEn_q[i];
                    end
                    out_q[i] <= raw[i] & appliedEn_q[i];
                end
            end

            AST_FROZEN_LOW: assert property (@(posedge clock) disable iff (!arst_n || clr)
                !appliedEn_q[i] |=> !out_q[i])
                else $error("frozen output went high");
            AST_CHANGE_WHEN_LOW: assert property (@(posedge clock) disable iff (!arst_n)
                $changed(appliedEn_q[i]) && !$past(clr) |-> !out_q[i] && !$past(raw[i]))
                else $error("freeze state changed while output high");
        end
    endgenerate

    // Output drivers float while master reset is held
    // Enable is taken straight from the pin so release costs only one clock
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= master_reset_hiz_n;
        end
    end

    assign clocksOut = pcdfc_clocks_t'(out_q);
    assign clocksOutEnable = oe_q;
    assign detectorFeedback = detFb_q;
    assign phaseUp = up_q;
    assign phaseDown = down_q;

    AST_HIZ_IN_RESET: assert property (@(posedge clock) disable iff (!arst_n)
        clr |=> !clocksOutEnable && (out_q == '0))
        else $error("outputs driven during master reset");
    AST_ALL_ACTIVE_AFTER_RESET: assert property (@(posedge clock) disable iff (!arst_n)
        clr |=> (appliedEn_q == ENABLES_RESET) && (reqEn_q == ENABLES_RESET))
        else $error("outputs not all active after reset");
    AST_INT_FB_PERIOD: assert property (@(posedge clock) disable iff (!arst_n || clr)
        $rose(fbCnt_q[INT_FB_WIDTH-1]) |-> ##32 $rose(fbCnt_q[INT_FB_WIDTH-1]))
        else $error("internal feedback period is not 32 VCO cycles");
    AST_STROBE_APPLIES: assert property (@(posedge clock) disable iff (!arst_n || clr)
        strobeFall |=> reqEn_q == {NUM_OUTPUTS{~$past(commonFreeze)}})
        else $error("common freeze not applied on strobe fall");
    AST_SERIAL_SHIFT: assert property (@(posedge clock) disable iff (!arst_n || clr)
        serRise && !strobeFall |=> reqEn_q == $past(shiftNext))
        else $error("serial enable bit not shifted in");
    AST_BYPASS_HOLD: assert property (@(posedge clock) disable iff (!arst_n || clr)
        !pllEnable && !tcRise |=> $stable(tickCnt_q) && $stable(busCnt_q))
        else $error("divider moved in bypass without a test clock edge");
    AST_HALVING: assert property (@(posedge clock) disable iff (!arst_n || clr)
        pllEnable && !vco_range_select && !halfPhase_q |=> $stable(tickCnt_q))
        else $error("halving stage skipped with range select low");
    AST_BUS_ENABLE_FULL: assert property (@(posedge clock) disable iff (!arst_n || clr)
        (busDivSelect == 2'h0) && (busCnt_q < busPeriod) |-> raw[IDX_BUS_CLOCK_ENABLE_OUT])
        else $error("bus enable low when bus runs at processor enable rate");

    // Pads come back one edge after the master reset input returns high
    AST_OE_ON_RELEASE: assert property (@(posedge clock) disable iff (!arst_n)
        !clr |=> clocksOutEnable)
        else $error("outputs still floating after master reset released");

    // Detector input is the chosen feedback, one clock late
    AST_FEEDBACK_ROUTE: assert property (@(posedge clock) disable iff (!arst_n || clr)
        feedback_source_select |=> detectorFeedback == $past(fbCnt_q[INT_FB_WIDTH-1]))
        else $error("internal feedback not routed to the detector");
    AST_EXT_FEEDBACK_ROUTE: assert property (@(posedge clock) disable iff (!arst_n || clr)
        !feedback_source_select |=> detectorFeedback == $past(externalFeedback))
        else $error("returned output not routed to the detector");

    // A lone reference edge pulls up, a lone feedback edge pulls down or ends the up pulse
    AST_PFD_UP: assert property (@(posedge clock) disable iff (!arst_n || clr)
        refRise && !fbRise && !down_q |=> phaseUp && !phaseDown)
        else $error("reference edge did not raise the up output");
    AST_PFD_DOWN: assert property (@(posedge clock) disable iff (!arst_n || clr)
        fbRise && !refRise && !up_q |=> phaseDown && !phaseUp)
        else $error("feedback edge did not raise the down output");
    AST_PFD_RESOLVE: assert property (@(posedge clock) disable iff (!arst_n || clr)
        up_q && fbRise && !refRise |=> !phaseUp && !phaseDown)
        else $error("feedback edge did not end the up pulse");

    // Divider steps: one per test clock edge in bypass, one per clock at full VCO range
    AST_BYPASS_STEP: assert property (@(posedge clock) disable iff (!arst_n || clr)
        !pllEnable && tcRise |=> tickCnt_q == $past(tickCnt_q) + 2'h1)
        else $error("divider did not step on a test clock edge in bypass");
    AST_VCO_FULL_RATE: assert property (@(posedge clock) disable iff (!arst_n || clr)
        pllEnable && vco_range_select |=> tickCnt_q == $past(tickCnt_q) + 2'h1)
        else $error("halving stage kept with range select high");

    // Bus counter wraps at the strap period so bus and local waves stay locked
    AST_BUS_WRAP: assert property (@(posedge clock) disable iff (!arst_n || clr)
        tick && busWrap |=> busCnt_q == '0)
        else $error("bus counter did not wrap at the end of its period");

    COV_COMMON_FREEZE: cover property (@(posedge clock) disable iff (!arst_n) strobeFall && commonFreeze);
    COV_SERIAL_SHIFT: cover property (@(posedge clock) disable iff (!arst_n) serRise && !freezeSerialData);
    COV_UNFREEZE: cover property (@(posedge clock) disable iff (!arst_n) $rose(appliedEn_q[IDX_BUS]));
    COV_BYPASS_TICK: cover property (@(posedge clock) disable iff (!arst_n) !pllEnable && tcRise);
    COV_EXT_FEEDBACK: cover property (@(posedge clock) disable iff (!arst_n) !feedback_source_select && fbRise);

endmodule // pcdfc_clock_control

// file: common/pcdfc_pkg.sv
/*
 * Shared constants and types of the PLL clock divider and freeze control.
 * Assumes one clock at the VCO rate; every other input is synchronous to it.
 */
package pcdfc_pkg;

    localparam int NUM_OUTPUTS = 5;
    localparam int IDX_DOUBLE = 0;
    localparam int IDX_PROCESSOR_CLOCK_ENABLE_OUT = 1;
    localparam int IDX_BUS_CLOCK_ENABLE_OUT = 2;
    localparam int IDX_BUS = 3;
    localparam int IDX_LOCAL = 4;

    localparam int INT_FB_DIVIDE = 32;
    localparam int INT_FB_WIDTH = $clog2(INT_FB_DIVIDE);
    localparam int PROCESSOR_CLOCK_ENABLE_OUT_TICKS = 4;
    localparam int BUS_CNT_WIDTH = 5;
    localparam int LOCAL_POS_WIDTH = 7;

    localparam logic [1:0] LOCAL_SEL_PROCESSOR_CLOCK_ENABLE_OUT = 2'h3;
    localparam logic [NUM_OUTPUTS-1:0] ENABLES_RESET = '1;

    // Clock outputs as one bundle, double rate clock in bit 0
    typedef struct packed {
        logic localBusClock;
        logic busClock;
        logic bus_clock_enable_out;
        logic processor_clock_enable_out;
        logic double_rate_processor_clock;
    } pcdfc_clocks_t;

endpackage

// file: test/pcdfc_partner.sv
/* Freeze controller and clock load model at the far side of the clock block.
   Assumes it is stepped by the VCO clock and drives its pins on rising edges. */
`timescale 1ns/1ps
module pcdfc_partner (
    input wire logic clock,
    input pcdfc_pkg::pcdfc_clocks_t clocksOut,
    output logic freezeSerialClock,
    output logic freezeSerialData,
    output logic commonFreeze,
    output logic freezeStrobe,
    output logic externalFeedback
);
    import pcdfc_pkg::*;
    // Slowest output comes back as feedback, like a board return trace
    assign externalFeedback = clocksOut.localBusClock;
    // Serial clock stands low between frames
    initial begin
        freezeSerialClock = 1'b0;
        freezeSerialData = 1'b0;
        commonFreeze = 1'b0;
        freezeStrobe = 1'b0;
    end
    // Each level is held three clocks, so the sampler never misses one
    task automatic hold(input logic c, input logic d);
        @(posedge clock);
        freezeSerialClock <= c;
        freezeSerialData <= d;
        repeat (2) @(posedge clock);
    endtask
    // Last output's bit goes first so it ends up furthest along
    task automatic shiftIn(input logic [NUM_OUTPUTS-1:0] en);
        for (int i = NUM_OUTPUTS - 1; i >= 0; i--) begin
            hold(1'b0, en[i]);
            hold(1'b1, en[i]);
        end
        hold(1'b0, ~en[0]);
    endtask
    // Level is settled before the strobe falls, never together with it
    task automatic strobe(input logic frz);
        @(posedge clock);
        commonFreeze <= frz;
        freezeStrobe <= 1'b1;
        repeat (3) @(posedge clock);
        freezeStrobe <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
endmodule // pcdfc_partner

// file: test/tb_pcdfc_clock_control.sv
/* Self-checking bench for the clock control block with a counting model.
   Assumes the partner model drives the freeze pins and returns feedback. */
`timescale 1ns/1ps
module tb_pcdfc_clock_control;
    import pcdfc_pkg::*;
    localparam int W = 288;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic master_reset_hiz_n = 1'b1;
    logic pllEnable = 1'b1;
    logic vco_range_select = 1'b1;
    logic test_reference_clock_in = 1'b0;
    logic feedback_source_select = 1'b1;
    logic [1:0] busDivSelect = 2'h0;
    logic [1:0] localDivSelect = 2'h0;
    logic [1:0] refCnt = 2'h0;
    logic freezeSerialClock, freezeSerialData, commonFreeze, freezeStrobe, externalFeedback;
    logic clocksOutEnable, detectorFeedback, phaseUp, phaseDown;
    pcdfc_clocks_t clocksOut;
    wire [7:0] cur = {phaseDown, phaseUp, detectorFeedback, clocksOut};
    logic [7:0] prevQ = '0;
    logic prevExt = 1'b0;
    int rises[8], highs[8], run[2];
    int err_total = 0;
    int n_compared = 0;
    int s = 1;
    bit mon = 1'b0;
    bit phs = 1'b1;
    bit extChk = 1'b0;

    pcdfc_clock_control pcdfc_clock_control_i (
        .clock, .arst_n, .master_reset_hiz_n, .pllEnable, .vco_range_select, .test_reference_clock_in,
        .feedback_source_select, .externalFeedback, .busDivSelect, .localDivSelect, .freezeSerialClock,
        .freezeSerialData, .commonFreeze, .freezeStrobe, .clocksOut, .clocksOutEnable, .detectorFeedback,
        .phaseUp, .phaseDown
    );
    pcdfc_partner pcdfc_partner_i (
        .clock, .clocksOut, .freezeSerialClock, .freezeSerialData, .commonFreeze, .freezeStrobe,
        .externalFeedback
    );

    always #2.5 clock = ~clock;

    // Reference and test clock at a quarter of the VCO rate
    always @(posedge clock) begin
        refCnt <= refCnt + 2'h1;
        test_reference_clock_in <= refCnt[1];
    end

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0d seen %0d", n, exp, seen);
        end
    endtask

    // Counting model; sampled mid-cycle, away from the edge that moves outputs
    always @(negedge clock) begin
        for (int k = 0; k < 8; k++) begin
            rises[k] += int'(cur[k] && !prevQ[k]);
            highs[k] += int'(cur[k]);
        end
        for (int k = 0; k < 2; k++) begin
            if (mon && prevQ[k] && !cur[k]) check("high run", run[k], s * (k + 1));
            run[k] = cur[k] ? run[k] + 1 : 0;
        end
        // Processor enable rises at the same edge at which the double rate clock falls
        if (mon && phs && cur[1] && !prevQ[1]) check("phase", !cur[0] && prevQ[0], 1);
        if (extChk) check("feedback", detectorFeedback, prevExt);
        prevQ = cur;
        prevExt = externalFeedback;
    end

    // Cleared just after an edge, so exactly n samples are counted
    task automatic measure(input int n);
        @(posedge clock);
        rises = '{default: 0};
        highs = '{default: 0};
        repeat (n) @(posedge clock);
    endtask

    // Straps only change under master reset, else the divider phases drift apart
    task automatic runWindow(input int b, input int l, input int sc);
        int pb, pl, ex;
        int per[8];
        pb = 4 * (b + 1);
        pl = (l == 3) ? 4 : (l + 1) * pb;
        per = '{2, 4, pb, pb, pl, 32, 32, 32};
        @(posedge clock);
        busDivSelect <= 2'(b);
        localDivSelect <= 2'(l);
        master_reset_hiz_n <= 1'b0;
        mon = 0;
        s = sc;
        repeat (2) @(negedge clock);
        check("oe in reset", clocksOutEnable, 0);
        check("outs in reset", clocksOut, 0);
        @(posedge clock);
        master_reset_hiz_n <= 1'b1;
        repeat (12) @(posedge clock);
        check("oe out of reset", clocksOutEnable, 1);
        mon = 1;
        measure(W * sc);
        // Reference outruns internal feedback: one pull-up per feedback period and never a pull-down
        for (int k = 0; k < 8; k++) begin
            ex = ((k == 2 && b == 0) || k == 7) ? 0 : W / per[k];
            if (k < 5 || sc == 1) check("rises", rises[k], ex);
            if (k < 5) check("highs", highs[k], (k == 2) ? 4 * W * sc / pb : W * sc / 2);
        end
    endtask

    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [NUM_OUTPUTS-1:0] en;
        void'($urandom(80045));
        repeat (3) @(negedge clock);
        check("oe in por", clocksOutEnable, 0);
        @(posedge clock);
        arst_n <= 1'b1;
        mon = 1;
        measure(W);
        check("por active", highs[0] + highs[4], W);
        for (int b = 0; b < 4; b++) begin
            for (int l = 0; l < 4; l++) begin
                runWindow(b, l, 1);
            end
        end
        @(posedge clock);
        vco_range_select <= 1'b0;
        runWindow(3, 2, 2);
        @(posedge clock);
        pllEnable <= 1'b0;
        runWindow(3, 2, 4);
        @(posedge clock);
        pllEnable <= 1'b1;
        vco_range_select <= 1'b1;
        runWindow(1, 1, 1);
        // Random per-output enables; bus period 8 makes every output high half the time
        en = NUM_OUTPUTS'($urandom);
        phs = 0;
        pcdfc_partner_i.shiftIn(en);
        repeat (20) @(posedge clock);
        measure(W);
        for (int k = 0; k < 5; k++) check("serial", highs[k], en[k] ? W / 2 : 0);
        for (int f = 1; f >= 0; f--) begin
            pcdfc_partner_i.strobe(1'(f));
            repeat (20) @(posedge clock);
            phs = (f == 0);
            measure(W);
            for (int k = 0; k < 5; k++) check("common", highs[k], f ? 0 : W / 2);
        end
        @(posedge clock);
        feedback_source_select <= 1'b0;
        // Long settle, so an edge made by the switch itself falls outside the window
        repeat (20) @(posedge clock);
        extChk = 1;
        measure(W);
        extChk = 0;
        // Returned local bus clock has period 16, four reference periods
        check("pfd up", rises[6], W / 16);
        check("pfd down", rises[7], 0);
        stop_test;
    end

    // Cuts a hang well past the roughly eight thousand cycles of the run
    initial begin
        #100000;
        err_total++;
        stop_test;
    end
endmodule // tb_pcdfc_clock_control
